//--- hw/sbm_bar_config.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sbm_regs.svh"
module sbm_bar_config (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire sbm_pkg::sbm_req_type req,
	output logic hitValid,
	output logic hitMiss,
	output logic [2:0] hitBar,
	output logic [5:0] barActive,
	output logic msixVisible,
	output logic [2:0] msixTblBar,
	output logic [28:0] msixTblOffset,
	output logic [10:0] msixTblSize,
	output logic [2:0] msixPbaBar,
	output logic [28:0] msixPbaOffset,
	output logic [15:0] pmFirst,
	output logic [15:0] pmSecond
);
	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	sbm_pkg::sbm_slot_cfg_type [5:0] ctrl_r;
	sbm_pkg::sbm_base_arr_type base_r;
	logic legacy_r;
	logic msixEn_r;
	logic secondEn_r;
	logic [31:0] tbl_r;
	logic [10:0] tblSize_r;
	logic [31:0] pba_r;
	logic [15:0] pm_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	sbm_pkg::sbm_eff_arr_type eff;
	logic [5:0] effAct;
	logic [5:0] effIo;
	logic [5:0] eff64;
	logic [5:0] effPref;
	logic [5:0] effErr;
	logic [5:0] effSmall;
	logic anyMem;
	logic tblOk;
	logic pbaOk;
	logic decHit;
	logic [2:0] decIdx;

	function automatic logic isSlotReg(input logic [7:0] a, input logic [7:0] b);
		return (a >= b) && (a < b + 8'(4 * `SBM_NSLOT)) && (a[1:0] == 2'h0);
	endfunction : isSlotReg

	function automatic logic [2:0] slotIdx(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] d;
		d = a - b;
		return d[4:2];
	endfunction : slotIdx

	function automatic logic birOk(input logic [2:0] bir, input logic [5:0] act,
			input logic [5:0] io);
		return (bir <= `SBM_LAST_SLOT) && act[bir] && !io[bir];
	endfunction : birOk

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r <= '0;
		end else if (regWr && isSlotReg(regAddr, `SBM_CTRL_BASE)) begin
			ctrl_r[slotIdx(regAddr, `SBM_CTRL_BASE)] <= {regWdata[13:8], regWdata[3:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			base_r <= '0;
		end else if (regWr && isSlotReg(regAddr, `SBM_BASE_BASE)) begin
			base_r[slotIdx(regAddr, `SBM_BASE_BASE)] <= regWdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			legacy_r <= 1'b0;
			msixEn_r <= 1'b0;
			secondEn_r <= 1'b0;
		end else if (regWr && regAddr == `SBM_GCFG) begin
			legacy_r <= regWdata[0];
			msixEn_r <= regWdata[1];
			secondEn_r <= regWdata[2];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tbl_r <= '0;
			tblSize_r <= '0;
			pba_r <= '0;
		end else if (regWr) begin
			if (regAddr == `SBM_MSIX_TBL) begin
				tbl_r <= regWdata;
			end else if (regAddr == `SBM_MSIX_SIZE) begin
				tblSize_r <= regWdata[10:0];
			end else if (regAddr == `SBM_MSIX_PBA) begin
				pba_r <= regWdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pm_r <= '0;
		end else if (regWr && regAddr == `SBM_PM) begin
			pm_r <= regWdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// per-slot legality
	// ------------------------------------------------------------
	for (genvar g = 0; g < `SBM_NSLOT; g++) begin : gSlot
		logic upper;
		if (g == 0) begin : gFirst
			assign upper = 1'b0;
		end else begin : gNext
			assign upper = eff[g - 1].active & eff[g - 1].is64;
		end
		sbm_slot_check uCheck (
			.legacy(legacy_r),
			.upperTaken(upper),
			.isLast(3'(g) == `SBM_LAST_SLOT),
			.cfg(ctrl_r[g]),
			.eff(eff[g])
		);
		assign effAct[g] = eff[g].active;
		assign effIo[g] = eff[g].io;
		assign eff64[g] = eff[g].is64;
		assign effPref[g] = eff[g].pref;
		assign effErr[g] = eff[g].err;
		assign effSmall[g] = eff[g].smallMem;
	end

	// ------------------------------------------------------------
	// msi-x placement
	// ------------------------------------------------------------
	always_comb begin
		anyMem = |(effAct & ~effIo);
		tblOk = birOk(tbl_r[2:0], effAct, effIo);
		pbaOk = birOk(pba_r[2:0], effAct, effIo);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			msixVisible <= 1'b0;
			msixTblBar <= '0;
			msixTblOffset <= '0;
			msixTblSize <= '0;
			msixPbaBar <= '0;
			msixPbaOffset <= '0;
		end else begin
			msixVisible <= msixEn_r & anyMem & tblOk & pbaOk;
			msixTblBar <= tbl_r[2:0];
			msixTblOffset <= tbl_r[31:3];
			msixTblSize <= tblSize_r;
			msixPbaBar <= pba_r[2:0];
			msixPbaOffset <= pba_r[31:3];
		end
	end

	// ------------------------------------------------------------
	// power management fan-out
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pmFirst <= '0;
			pmSecond <= '0;
		end else begin
			pmFirst <= pm_r;
			pmSecond <= secondEn_r ? pm_r : 16'h0;
		end
	end

	// ------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------
	sbm_hit_decode uDecode (
		.req(req),
		.effs(eff),
		.bases(base_r),
		.hit(decHit),
		.idx(decIdx)
	);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hitValid <= 1'b0;
			hitMiss <= 1'b0;
			hitBar <= '0;
			barActive <= '0;
		end else begin
			hitValid <= decHit;
			hitMiss <= req.valid & !decHit;
			hitBar <= decIdx;
			barActive <= effAct;
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always_comb begin
		rdata_nxt = 32'h0;
		if (isSlotReg(regAddr, `SBM_CTRL_BASE)) begin
			rdata_nxt[13:8] = ctrl_r[slotIdx(regAddr, `SBM_CTRL_BASE)].size;
			rdata_nxt[3:0] = ctrl_r[slotIdx(regAddr, `SBM_CTRL_BASE)][3:0];
		end else if (isSlotReg(regAddr, `SBM_BASE_BASE)) begin
			rdata_nxt = base_r[slotIdx(regAddr, `SBM_BASE_BASE)];
		end else if (regAddr == `SBM_GCFG) begin
			rdata_nxt[2:0] = {secondEn_r, msixEn_r, legacy_r};
		end else if (regAddr == `SBM_MSIX_TBL) begin
			rdata_nxt = tbl_r;
		end else if (regAddr == `SBM_MSIX_SIZE) begin
			rdata_nxt[10:0] = tblSize_r;
		end else if (regAddr == `SBM_MSIX_PBA) begin
			rdata_nxt = pba_r;
		end else if (regAddr == `SBM_PM) begin
			rdata_nxt[15:0] = pm_r;
		end else if (regAddr == `SBM_STATUS) begin
			rdata_nxt[5:0] = effAct;
			rdata_nxt[11:6] = effErr;
			rdata_nxt[17:12] = effSmall;
			rdata_nxt[20:18] = {pbaOk, tblOk, msixVisible};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_r <= '0;
		end else if (regRd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= '0;
		end
	end

	assign regRdata = rdata_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	ioNarrow_a: assert property ((effAct & effIo & (eff64 | effPref)) == 6'h0)
		else $error("io slot marked wide or prefetchable");

	ioLegacy_a: assert property (!legacy_r |-> (effAct & effIo) == 6'h0)
		else $error("io slot live outside legacy mode");

	upperPair_a: assert property ((((effAct & eff64) << 1) & effAct) == 6'h0)
		else $error("upper half slot acting alone");

	sizeFloor_a: assert property (!legacy_r && effAct[0] |-> eff[0].size >= `SBM_MIN_MEM_LOG2)
		else $error("aperture below 128 bytes outside legacy mode");

	prefWide_a: assert property (!legacy_r |->
		(effAct[4:0] & effPref[4:0] & ~eff64[4:0]) == 5'h0)
		else $error("narrow prefetchable slot outside legacy mode");

	msixGate_a: assert property (msixVisible |-> $past(anyMem))
		else $error("msi-x exposed without a memory slot");

	tblLower_a: assert property (msixVisible |->
		$past(effAct[tbl_r[2:0]] && !effIo[tbl_r[2:0]]))
		else $error("table indicator names a dead slot");

	pmMirror_a: assert property (secondEn_r && $stable(pm_r) |=> pmSecond == pmFirst)
		else $error("second function power settings differ");

	hitLive_a: assert property (hitValid |-> $past(effAct[decIdx]))
		else $error("hit on a disabled slot");

	hitType_a: assert property (
		req.valid && ((effAct & effIo) == 6'h0) && req.io |=> !hitValid)
		else $error("io request claimed without a live io slot");

	readOnce_a: assert property (!regRd |=> regRdata == 32'h0)
		else $error("read data outside its cycle");

	ioPref_a: assert property ((effIo & effPref) == 6'h0)
		else $error("io slot marked prefetchable");

	lastNarrow_a: assert property (!(effAct[`SBM_LAST_SLOT] && eff64[`SBM_LAST_SLOT]))
		else $error("last slot live as a wide slot");

	sizeCeil_a: assert property (effAct[0] && !eff64[0] |-> eff[0].size <= `SBM_MAX32_LOG2)
		else $error("narrow aperture above 2 GB");

	legacyFloor_a: assert property (effAct[0] |-> eff[0].size >= `SBM_MIN_LEG_LOG2)
		else $error("aperture below 16 bytes");

	smallWarn_a: assert property ((effSmall & ~(effAct & ~effIo)) == 6'h0)
		else $error("small aperture warning on a non-memory slot");

	liveNoErr_a: assert property ((effAct & effErr) == 6'h0)
		else $error("slot both live and in error");

	msixEnable_a: assert property (msixVisible |-> $past(msixEn_r))
		else $error("msi-x exposed while disabled");

	tblCopy_a: assert property (msixTblBar == $past(tbl_r[2:0]))
		else $error("table indicator not reported");

	pbaLive_a: assert property (msixVisible |->
		$past(effAct[pba_r[2:0]] && !effIo[pba_r[2:0]]))
		else $error("pending array indicator names a dead slot");

	pbaCopy_a: assert property (msixPbaBar == $past(pba_r[2:0]))
		else $error("pending array indicator not reported");

	pmFirst_a: assert property (pmFirst == $past(pm_r))
		else $error("first function power settings stale");

	pmGate_a: assert property (!$past(secondEn_r) |-> pmSecond == 16'h0)
		else $error("second function power settings while disabled");

	hitExcl_a: assert property (!(hitValid && hitMiss))
		else $error("hit and miss together");

	hitCause_a: assert property (hitValid || hitMiss |-> $past(req.valid))
		else $error("decode answer without a request");

	noSlotMiss_a: assert property (req.valid && effAct == 6'h0 |=> hitMiss)
		else $error("request not refused with no live slot");

	memType_a: assert property (
		req.valid && ((effAct & ~effIo) == 6'h0) && !req.io |=> !hitValid)
		else $error("memory request claimed without a live memory slot");

	barCopy_a: assert property (barActive == $past(effAct))
		else $error("slot enables not reported");
endmodule : sbm_bar_config
`default_nettype wire

//--- hw/sbm_regs.svh
// Behaviour
// - An I/O slot is always 32 bits wide and its prefetchable setting is ignored.
// - An I/O slot may only come alive while the endpoint runs in legacy mode.
// - A memory slot may be 32 or 64 bits wide and either width may be prefetchable.
// - A 64-bit slot takes the next slot as its upper half, which then never acts alone.
// - Outside legacy mode memory apertures run from 128 bytes to 2 GB (32-bit) or 8 EB (64-bit).
// - In legacy mode apertures start at 16 bytes, topping out at 2 GB (32-bit, I/O) or 8 EB.
// - A live slot claims only requests of its own space type, memory or I/O.
// - Outside legacy mode every prefetchable slot but the last must be 64 bits wide.
// - Memory apertures below 4 KB are flagged as unwise; I/O apertures start at 16 bytes.
// - The MSI-X capability is exposed only while at least one memory slot is live.
// - The vector table is an offset from its indicated slot, the lower half of a 64-bit pair.
// - The pending-bit array has its own offset and its own, possibly different, slot indicator.
// - Power-management settings reach both functions alike while the second one is enabled.
// - Each slot has its own enable and a disabled slot claims nothing.
`ifndef SBM_REGS_SVH
`define SBM_REGS_SVH

`define SBM_NSLOT 6
`define SBM_LAST_SLOT 3'h5
`define SBM_CTRL_BASE 8'h00
`define SBM_BASE_BASE 8'h20
`define SBM_GCFG 8'h40
`define SBM_MSIX_TBL 8'h44
`define SBM_MSIX_SIZE 8'h48
`define SBM_MSIX_PBA 8'h4C
`define SBM_PM 8'h50
`define SBM_STATUS 8'h54
`define SBM_MIN_MEM_LOG2 6'h07
`define SBM_MIN_LEG_LOG2 6'h04
`define SBM_MAX32_LOG2 6'h1F
`define SBM_MAX64_LOG2 6'h3F
`define SBM_REC_MEM_LOG2 6'h0C

`endif

//--- hw/sbm_pkg.sv
`include "sbm_regs.svh"
package sbm_pkg;
	typedef struct packed {
		logic [5:0] size;
		logic pref;
		logic is64;
		logic io;
		logic en;
	} sbm_slot_cfg_type;

	typedef struct packed {
		logic active;
		logic err;
		logic smallMem;
		logic io;
		logic is64;
		logic pref;
		logic [5:0] size;
	} sbm_slot_eff_type;

	typedef struct packed {
		logic valid;
		logic io;
		logic [63:0] addr;
	} sbm_req_type;

	typedef sbm_slot_eff_type [5:0] sbm_eff_arr_type;
	typedef logic [5:0][31:0] sbm_base_arr_type;

	function automatic logic sizeOk(input logic legacy, input logic is64,
			input logic [5:0] size);
		logic [5:0] lo;
		logic [5:0] hi;
		lo = legacy ? `SBM_MIN_LEG_LOG2 : `SBM_MIN_MEM_LOG2;
		hi = is64 ? `SBM_MAX64_LOG2 : `SBM_MAX32_LOG2;
		return (size >= lo) && (size <= hi);
	endfunction : sizeOk
endpackage : sbm_pkg

//--- hw/sbm_slot_check.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbm_regs.svh"
module sbm_slot_check (
	input wire logic legacy,
	input wire logic upperTaken,
	input wire logic isLast,
	input wire sbm_pkg::sbm_slot_cfg_type cfg,
	output var sbm_pkg::sbm_slot_eff_type eff
);
	logic wide;
	logic usable;
	logic bad;

	always_comb begin
		usable = cfg.en & !upperTaken;
		wide = !cfg.io & cfg.is64;
		bad = 1'b0;
		if (cfg.io && !legacy) begin
			bad = 1'b1;
		end
		if (wide && isLast) begin
			bad = 1'b1;
		end
		if (!sbm_pkg::sizeOk(legacy, wide, cfg.size)) begin
			bad = 1'b1;
		end
		if (!legacy && !cfg.io && cfg.pref && !wide && !isLast) begin
			bad = 1'b1;
		end
		eff.io = cfg.io;
		eff.is64 = wide;
		eff.pref = cfg.pref & !cfg.io;
		eff.size = cfg.size;
		eff.err = usable & bad;
		eff.active = usable & !bad;
		eff.smallMem = usable & !bad & !cfg.io & (cfg.size < `SBM_REC_MEM_LOG2);
	end
endmodule : sbm_slot_check
`default_nettype wire

//--- hw/sbm_hit_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbm_regs.svh"
module sbm_hit_decode (
	input wire sbm_pkg::sbm_req_type req,
	input wire sbm_pkg::sbm_eff_arr_type effs,
	input wire sbm_pkg::sbm_base_arr_type bases,
	output logic hit,
	output logic [2:0] idx
);
	function automatic logic slotHit(input sbm_pkg::sbm_slot_eff_type e,
			input logic [31:0] lo, input logic [31:0] hi,
			input sbm_pkg::sbm_req_type r);
		logic [63:0] mask;
		logic [63:0] base;
		mask = ~((64'h1 << e.size) - 64'h1);
		base = e.is64 ? {hi, lo} : {32'h0, lo};
		return e.active && (r.io == e.io)
			&& ((r.addr & mask) == (base & mask));
	endfunction : slotHit

	always_comb begin
		hit = 1'b0;
		idx = 3'h0;
		for (int i = `SBM_NSLOT - 1; i >= 0; i--) begin
			if (req.valid && slotHit(effs[i], bases[i], bases[(i + 1) % `SBM_NSLOT], req)) begin
				hit = 1'b1;
				idx = 3'(i);
			end
		end
	end
endmodule : sbm_hit_decode
`default_nettype wire

//--- verif/sbm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbm_host_model (
	input wire logic clk,
	output var sbm_pkg::sbm_req_type req
);
	// -----------------------------
	// requester side of the decoder
	// -----------------------------
	// vector table and pending bits stay on this side
	initial req = '0;

	// one doubleword address per request, merged writes included
	task automatic issue(input logic io, input logic [63:0] a);
		@(posedge clk);
		req <= '{valid: 1'b1, io: io, addr: a};
		@(posedge clk);
		// released bus shows no stale address
		req <= '{valid: 1'b0, io: ~io, addr: ~a};
	endtask : issue
endmodule : sbm_host_model
`default_nettype wire

//--- verif/sbm_bar_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sbm_bar_config_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	sbm_pkg::sbm_req_type req;
	logic hitValid, hitMiss, msixVisible;
	logic [2:0] hitBar, msixTblBar, msixPbaBar;
	logic [5:0] barActive;
	logic [28:0] msixTblOffset, msixPbaOffset;
	logic [10:0] msixTblSize;
	logic [15:0] pmFirst, pmSecond;
	int badCount = 0;
	int checks = 0;
	int cycles = 0;
	int seed = 32'h187FF865;
	logic [63:0] a;
	logic [8:0] t;
	logic [8:0] tbl [7] = '{9'h006, 9'h107, 9'h11F, 9'h020, 9'h043, 9'h144, 9'h1BF};

	sbm_host_model host (.clk(clk), .req(req));
	sbm_bar_config dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .req(req), .hitValid(hitValid),
		.hitMiss(hitMiss), .hitBar(hitBar), .barActive(barActive), .msixVisible(msixVisible),
		.msixTblBar(msixTblBar), .msixTblOffset(msixTblOffset), .msixTblSize(msixTblSize),
		.msixPbaBar(msixPbaBar), .msixPbaOffset(msixPbaOffset), .pmFirst(pmFirst),
		.pmSecond(pmSecond));

	initial begin
		forever #25 clk = ~clk;
	end

	// ---------------
	// helpers
	// ---------------
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : giveVerdict

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			badCount++;
			giveVerdict;
		end
	end

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			badCount++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : chk

	function automatic logic [31:0] ctl(input logic [5:0] s, input logic p, w, i);
		return {18'h0, s, 4'h0, p, w, i, 1'b1};
	endfunction : ctl

	function automatic logic in32(input logic [63:0] x, input logic [31:0] b, input int s);
		return x[63:32] == 32'h0 && ((x[31:0] ^ b) >> s) == 32'h0;
	endfunction : in32

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= ad;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= ad;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(regRdata === e, "read data");
	endtask : rd

	task automatic settle;
		@(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic rq(input logic io, input logic [63:0] x, input logic e, input logic [2:0] b);
		host.issue(io, x);
		@(negedge clk);
		chk(hitValid === e && hitMiss === !e && (!e || hitBar === b), "decode");
	endtask : rq

	// ---------------
	// main sequence
	// ---------------
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(barActive === 6'h00 && msixVisible === 1'b0 && hitValid === 1'b0, "reset");
		wr(8'h20, 32'h10000000);
		wr(8'h00, ctl(6'h0C, 1'b0, 1'b0, 1'b0));
		settle;
		chk(barActive === 6'h01, "slot0 live");
		rd(8'h54, 32'h00180001);
		rq(1'b0, 64'h10000010, 1'b1, 3'h0);
		rq(1'b1, 64'h10000010, 1'b0, 3'h0);
		rq(1'b0, 64'h10001000, 1'b0, 3'h0);
		rq(1'b0, 64'h110000010, 1'b0, 3'h0);
		wr(8'h24, 32'h00002000);
		wr(8'h04, ctl(6'h04, 1'b1, 1'b1, 1'b1));
		settle;
		chk(barActive === 6'h01, "io outside legacy");
		wr(8'h40, 32'h00000001);
		settle;
		chk(barActive === 6'h03, "io in legacy");
		rq(1'b1, 64'h00002008, 1'b1, 3'h1);
		rq(1'b0, 64'h00002008, 1'b0, 3'h0);
		rq(1'b1, 64'h00002010, 1'b0, 3'h0);
		wr(8'h40, 32'h00000000);
		wr(8'h04, 32'h00000000);
		wr(8'h28, 32'h00100000);
		wr(8'h2C, 32'h00000003);
		wr(8'h0C, ctl(6'h0C, 1'b0, 1'b0, 1'b0));
		wr(8'h08, ctl(6'h14, 1'b1, 1'b1, 1'b0));
		settle;
		chk(barActive === 6'h05, "upper half");
		rq(1'b0, 64'h300100004, 1'b1, 3'h2);
		rq(1'b0, 64'h000100004, 1'b0, 3'h0);
		wr(8'h30, 32'h40000000);
		wr(8'h10, ctl(6'h0C, 1'b1, 1'b0, 1'b0));
		wr(8'h34, 32'h50000000);
		wr(8'h14, ctl(6'h0C, 1'b1, 1'b0, 1'b0));
		settle;
		chk(barActive === 6'h25, "narrow prefetchable");
		wr(8'h40, 32'h00000001);
		settle;
		chk(barActive === 6'h35, "legacy exempt");
		foreach (tbl[i]) begin
			t = tbl[i];
			wr(8'h40, {31'h0, t[6]});
			wr(8'h10, ctl(t[5:0], 1'b0, t[7], 1'b0));
			settle;
			chk(barActive[4] === t[8], "size range");
		end
		wr(8'h10, 32'h00000000);
		wr(8'h44, 32'h00000800);
		wr(8'h4C, 32'h00000202);
		wr(8'h48, 32'h000007FF);
		wr(8'h40, 32'h00000002);
		settle;
		chk(msixVisible === 1'b1 && msixTblBar === 3'h0 && msixTblOffset === 29'h100 &&
			msixPbaBar === 3'h2 && msixPbaOffset === 29'h40 && msixTblSize === 11'h7FF,
			"msix fields");
		wr(8'h44, 32'h00000803);
		settle;
		chk(msixVisible === 1'b0, "upper half indicator");
		wr(8'h44, 32'h00000800);
		wr(8'h00, 32'h00000000);
		wr(8'h08, 32'h00000000);
		wr(8'h0C, 32'h00000000);
		wr(8'h14, 32'h00000000);
		settle;
		chk(msixVisible === 1'b0 && barActive === 6'h00, "no memory slot");
		wr(8'h50, 32'h0000A5C3);
		settle;
		chk(pmFirst === 16'hA5C3 && pmSecond === 16'h0000, "pm single");
		wr(8'h40, 32'h00000006);
		settle;
		chk(pmSecond === 16'hA5C3, "pm both");
		wr(8'h60, 32'hFFFFFFFF);
		rd(8'h60, 32'h00000000);
		rd(8'h01, 32'h00000000);
		rd(8'h50, 32'h0000A5C3);
		wr(8'h00, ctl(6'h0C, 1'b0, 1'b0, 1'b0));
		settle;
		repeat (40) begin
			a = {31'h0, ($random(seed) & 32'hF) == 32'h0, 32'h10000000 | ($random(seed) & 32'h3FFF)};
			rq(1'b0, a, in32(a, 32'h10000000, 12), 3'h0);
		end
		giveVerdict;
	end
endmodule : sbm_bar_config_tb
`default_nettype wire
